/* rtb_pkg.sv */
// Constants for the binary time and rate control block
package rtb_pkg;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DIV_W  = 15;
  localparam int unsigned RATE_W = 4;

  // Register offsets
  localparam logic [6:0] OFS_SEC      = 7'h00;
  localparam logic [6:0] OFS_SEC_AL   = 7'h01;
  localparam logic [6:0] OFS_MIN      = 7'h02;
  localparam logic [6:0] OFS_MIN_AL   = 7'h03;
  localparam logic [6:0] OFS_HOUR     = 7'h04;
  localparam logic [6:0] OFS_HOUR_AL  = 7'h05;
  localparam logic [6:0] OFS_WDAY     = 7'h06;
  localparam logic [6:0] OFS_MDAY     = 7'h07;
  localparam logic [6:0] OFS_MONTH    = 7'h08;
  localparam logic [6:0] OFS_YEAR     = 7'h09;
  localparam logic [6:0] OFS_OSC_RATE = 7'h0A;
  localparam logic [6:0] OFS_MODE     = 7'h0B;
  localparam logic [6:0] OFS_FLAGS    = 7'h0C;
  localparam logic [6:0] OFS_BACKUP   = 7'h0D;
  localparam logic [6:0] OFS_CENTURY  = 7'h48;
  localparam logic [6:0] OFS_MDAY_AL  = 7'h49;
  localparam logic [6:0] OFS_EXT_CTRL = 7'h4A;

  // Field positions
  localparam int unsigned A_UPDATE_PENDING = 7;
  localparam int unsigned A_BANK_SEL       = 4;
  localparam int unsigned A_OSC_LO         = 5;
  localparam int unsigned A_OSC_HI         = 6;
  localparam int unsigned B_SET            = 7;
  localparam int unsigned B_PIE            = 6;
  localparam int unsigned B_UIE            = 4;
  localparam int unsigned B_SQUARE_WAVE_ENABLE           = 3;
  localparam int unsigned B_BINARY         = 2;
  localparam int unsigned B_HOUR24         = 1;
  localparam int unsigned C_PERIODIC       = 6;
  localparam int unsigned HOUR_PM          = 7;
  localparam int unsigned EXT_FIXED_32KHZ_OUTPUT_ENABLE         = 0;

  // Values and masks
  localparam logic [7:0] SEC_WR_MASK    = 8'h7F;
  localparam logic [7:0] HOUR_VAL_MASK  = 8'h7F;
  localparam logic [6:0] OSC_CTRL_WMASK = 7'h7F;
  localparam logic [7:0] BACKUP_VALID   = 8'h80;
  localparam logic [7:0] READ_ZERO      = 8'h00;
  localparam logic [1:0] OSC_RUN        = 2'h1;
  localparam logic [1:0] OSC_HOLD       = 2'h3;

  // Calendar limits in binary
  localparam logic [7:0] SEC_MAX    = 8'h3B;
  localparam logic [7:0] HOUR24_MAX = 8'h17;
  localparam logic [7:0] HOUR12_MAX = 8'h0C;
  localparam logic [7:0] HOUR12_PRE = 8'h0B;
  localparam logic [7:0] ONE        = 8'h01;
  localparam logic [7:0] WDAY_MAX   = 8'h07;
  localparam logic [7:0] MONTH_MAX  = 8'h0C;
  localparam logic [7:0] YEAR_MAX   = 8'h63;
  localparam logic [7:0] DAYS_31    = 8'h1F;
  localparam logic [7:0] DAYS_30    = 8'h1E;
  localparam logic [7:0] DAYS_29    = 8'h1D;
  localparam logic [7:0] DAYS_28    = 8'h1C;
  localparam logic [7:0] FEB        = 8'h02;
  localparam logic [7:0] APR        = 8'h04;
  localparam logic [7:0] JUN        = 8'h06;
  localparam logic [7:0] SEP        = 8'h09;
  localparam logic [7:0] NOV        = 8'h0B;
  localparam logic [7:0] TEN        = 8'h0A;

  // Divider chain timing
  localparam int unsigned OSC_HZ       = 32768;
  localparam logic [14:0] DIV_START    = 15'h4000;
  localparam logic [14:0] DIV_LAST     = 15'h7FFF;
  localparam int unsigned UIP_LEAD_US  = 244;
  localparam int unsigned UIP_TICKS    =
    (UIP_LEAD_US * OSC_HZ + 999999) / 1000000 + 1;
  localparam logic [14:0] UIP_START    = DIV_LAST - 15'(UIP_TICKS) + 15'h0001;
  localparam logic [3:0] RATE_OFF      = 4'h0;
  localparam logic [3:0] RATE_LOW_LAST = 4'h2;
  localparam logic [3:0] TAP_LOW_ADD   = 4'h5;
  localparam logic [3:0] TAP_HIGH_SUB  = 4'h2;
endpackage : rtb_pkg

/* rtb_sync3.sv */
// Three-stage pin synchroniser with agreement filter
module rtb_sync3
(
  input  wire logic i_mclk,
  input  wire logic i_reset_n,
  input  wire logic i_pin,
  output logic      o_level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  always_ff @(posedge i_mclk)
  begin
    s1_q <= i_pin;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // Change accepted only once stages two and three agree
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
      level_q <= 1'b0;
    else if (s2_q == s3_q)
      level_q <= s3_q;
  end

  assign o_level = level_q;
endmodule : rtb_sync3

/* rtb_divchain.sv */
// Fifteen-stage count-up chain clocked by oscillator ticks
module rtb_divchain
(
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  input  wire logic        i_hold,
  input  wire logic        i_tick,
  output logic [14:0]      o_count,
  output logic             o_wrap
);
  logic [14:0] count_q;

  // Held at half count so the first wrap comes 500 ms after release
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n || i_hold)
      count_q <= rtb_pkg::DIV_START;
    else if (i_tick)
      count_q <= count_q + 15'h0001;
  end

  assign o_count = count_q;
  assign o_wrap  = i_tick && !i_hold && (count_q == rtb_pkg::DIV_LAST);
endmodule : rtb_divchain

/* rtb_core.sv */
// Binary timekeeping registers with oscillator and rate control
module rtb_core
(
  input  wire logic       i_mclk,
  input  wire logic       i_reset_n,
  input  wire logic       i_osc_32k,
  input  wire logic [6:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  output logic            o_square_wave_pin,
  output logic            o_periodic_pulse,
  output logic            o_update_pulse
);
  logic [7:0]  sec_q, sec_al_q, min_q, min_al_q, hour_q, hour_al_q;
  logic [7:0]  wday_q, mday_q, month_q, year_q, century_q, mday_al_q;
  logic [6:0]  osc_rate_q;
  logic [7:0]  mode_q;
  logic        fixed_32khz_output_enable_q;
  logic        periodic_flag_q;
  logic        update_pending_q;
  logic        osc_lvl;
  logic        osc_lvl_prev_q;
  logic        tick;
  logic        run;
  logic        chain_hold;
  logic [14:0] count;
  logic        wrap;
  logic        do_update;
  logic        tap_valid;
  logic [3:0]  tap_idx;
  logic        tap;
  logic        tap_prev_q;
  logic        tap_rise;
  logic        set_d;
  logic        binary_mode;
  logic        wr_a, wr_b, wr_bank1;
  logic [7:0]  rdata_d;
  logic [7:0]  sec_d, min_d, hour_d, wday_d, mday_d, month_d;
  logic [7:0]  year_d, century_d;

  // Binary-or-BCD conversion, selected by the format bit
  function automatic logic [7:0] to_bin(input logic [7:0] v,
                                        input logic       bin);
    logic [7:0] tens;
    tens = {4'h0, v[7:4]};
    if (bin)
      return v;
    return 8'((tens << 3) + (tens << 1)) + {4'h0, v[3:0]};
  endfunction : to_bin

  function automatic logic [7:0] from_bin(input logic [7:0] v,
                                          input logic       bin);
    logic [7:0] tens;
    logic [7:0] units;
    tens  = v / rtb_pkg::TEN;
    units = v % rtb_pkg::TEN;
    if (bin)
      return v;
    return {tens[3:0], units[3:0]};
  endfunction : from_bin

  rtb_sync3 u_sync
  (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_pin     (i_osc_32k),
    .o_level   (osc_lvl)
  );

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
      osc_lvl_prev_q <= 1'b0;
    else
      osc_lvl_prev_q <= osc_lvl;
  end

  assign tick = osc_lvl && !osc_lvl_prev_q;

  // Oscillator control decode
  assign run = osc_rate_q[rtb_pkg::A_OSC_HI:rtb_pkg::A_OSC_LO]
               == rtb_pkg::OSC_RUN;
  // 11X and every other non-run code keep the chain in reset
  assign chain_hold = !run;

  rtb_divchain u_div
  (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_hold    (chain_hold),
    .i_tick    (tick),
    .o_count   (count),
    .o_wrap    (wrap)
  );

  // First wrap 500 ms after release, then each second
  assign do_update = wrap && !mode_q[rtb_pkg::B_SET];

  // Tap select: rates 1 and 2 reuse the 256/128 Hz taps
  always_comb
  begin
    tap_valid = (osc_rate_q[3:0] != rtb_pkg::RATE_OFF) && run;
    if (osc_rate_q[3:0] <= rtb_pkg::RATE_LOW_LAST)
      tap_idx = osc_rate_q[3:0] + rtb_pkg::TAP_LOW_ADD;
    else
      tap_idx = osc_rate_q[3:0] - rtb_pkg::TAP_HIGH_SUB;
    tap = tap_valid && count[tap_idx];
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
      tap_prev_q <= 1'b0;
    else
      tap_prev_q <= tap;
  end

  assign tap_rise = tap && !tap_prev_q;

  // Register write decode
  assign wr_a     = i_wr && (i_addr == rtb_pkg::OFS_OSC_RATE);
  assign wr_b     = i_wr && (i_addr == rtb_pkg::OFS_MODE);
  assign wr_bank1 = i_wr && osc_rate_q[rtb_pkg::A_BANK_SEL];
  assign set_d    = wr_b ? i_wdata[rtb_pkg::B_SET] : mode_q[rtb_pkg::B_SET];
  assign binary_mode = mode_q[rtb_pkg::B_BINARY];

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
      osc_rate_q <= '0;
    else if (wr_a)
      osc_rate_q <= i_wdata[6:0] & rtb_pkg::OSC_CTRL_WMASK;
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
      mode_q <= '0;
    else if (wr_b)
    begin
      mode_q <= i_wdata;
      // Raising the inhibit bit drops the update-ended enable
      if (i_wdata[rtb_pkg::B_SET] && !mode_q[rtb_pkg::B_SET])
        mode_q[rtb_pkg::B_UIE] <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
      fixed_32khz_output_enable_q <= 1'b0;
    else if (wr_bank1 && i_addr == rtb_pkg::OFS_EXT_CTRL)
      fixed_32khz_output_enable_q <= i_wdata[rtb_pkg::EXT_FIXED_32KHZ_OUTPUT_ENABLE];
  end

  // Pending window covers the last ticks before the wrap
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
      update_pending_q <= 1'b0;
    else
      update_pending_q <= run && !set_d
                          && (count >= rtb_pkg::UIP_START);
  end

  // Periodic flag: a new edge beats a clearing read
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
      periodic_flag_q <= 1'b0;
    else if (tap_rise)
      periodic_flag_q <= 1'b1;
    else if (i_rd && i_addr == rtb_pkg::OFS_FLAGS)
      periodic_flag_q <= 1'b0;
  end

  // Next-second calendar arithmetic, done in binary
  always_comb
  begin
    logic [7:0] s, m, h, wd, md, mo, yr, ce, dim;
    logic       c_min, c_hour, c_day, c_mon, c_year, pm;
    s  = to_bin(sec_q & rtb_pkg::SEC_WR_MASK, binary_mode);
    m  = to_bin(min_q, binary_mode);
    h  = to_bin(hour_q & rtb_pkg::HOUR_VAL_MASK, binary_mode);
    pm = hour_q[rtb_pkg::HOUR_PM];
    wd = wday_q;
    md = to_bin(mday_q, binary_mode);
    mo = to_bin(month_q, binary_mode);
    yr = to_bin(year_q, binary_mode);
    ce = to_bin(century_q, binary_mode);
    c_hour = 1'b0;
    c_day  = 1'b0;
    c_mon  = 1'b0;
    c_year = 1'b0;
    dim    = rtb_pkg::DAYS_31;
    c_min  = (s >= rtb_pkg::SEC_MAX);
    s = c_min ? '0 : s + rtb_pkg::ONE;
    if (c_min)
    begin
      c_hour = (m >= rtb_pkg::SEC_MAX);
      m = c_hour ? '0 : m + rtb_pkg::ONE;
    end
    if (c_hour)
    begin
      if (mode_q[rtb_pkg::B_HOUR24])
      begin
        c_day = (h >= rtb_pkg::HOUR24_MAX);
        h = c_day ? '0 : h + rtb_pkg::ONE;
      end
      else if (h == rtb_pkg::HOUR12_PRE)
      begin
        // 11 to 12 flips the half; 11 PM to 12 AM is midnight
        c_day = pm;
        pm = !pm;
        h = rtb_pkg::HOUR12_MAX;
      end
      else if (h >= rtb_pkg::HOUR12_MAX)
        h = rtb_pkg::ONE;
      else
        h = h + rtb_pkg::ONE;
    end
    if (mo == rtb_pkg::FEB)
      dim = (yr[1:0] == 2'h0) ? rtb_pkg::DAYS_29 : rtb_pkg::DAYS_28;
    else if (mo == rtb_pkg::APR || mo == rtb_pkg::JUN
             || mo == rtb_pkg::SEP || mo == rtb_pkg::NOV)
      dim = rtb_pkg::DAYS_30;
    else
      dim = rtb_pkg::DAYS_31;
    if (c_day)
    begin
      wd = (wd >= rtb_pkg::WDAY_MAX) ? rtb_pkg::ONE
                                     : wd + rtb_pkg::ONE;
      c_mon = (md >= dim);
      md = c_mon ? rtb_pkg::ONE : md + rtb_pkg::ONE;
    end
    if (c_mon)
    begin
      c_year = (mo >= rtb_pkg::MONTH_MAX);
      mo = c_year ? rtb_pkg::ONE : mo + rtb_pkg::ONE;
    end
    if (c_year)
    begin
      if (yr >= rtb_pkg::YEAR_MAX)
      begin
        yr = '0;
        ce = (ce >= rtb_pkg::YEAR_MAX) ? '0 : ce + rtb_pkg::ONE;
      end
      else
        yr = yr + rtb_pkg::ONE;
    end
    sec_d     = from_bin(s, binary_mode);
    min_d     = from_bin(m, binary_mode);
    hour_d    = from_bin(h, binary_mode);
    hour_d[rtb_pkg::HOUR_PM] = pm && !mode_q[rtb_pkg::B_HOUR24];
    wday_d    = wd;
    mday_d    = from_bin(md, binary_mode);
    month_d   = from_bin(mo, binary_mode);
    year_d    = from_bin(yr, binary_mode);
    century_d = from_bin(ce, binary_mode);
  end

  // Time registers: no reset; an update keeps written reserved bits except hour bit 7 in 24-hour mode,
  // a same-cycle write to one register overrides its update value
  always_ff @(posedge i_mclk)
  begin
    if (do_update)
    begin
      sec_q     <= sec_d;
      min_q     <= min_d;
      hour_q    <= hour_d;
      wday_q    <= wday_d;
      mday_q    <= mday_d;
      month_q   <= month_d;
      year_q    <= year_d;
      century_q <= century_d;
    end
    if (i_wr)
    begin
      if (i_addr == rtb_pkg::OFS_SEC)
        sec_q <= i_wdata & rtb_pkg::SEC_WR_MASK;
      else if (i_addr == rtb_pkg::OFS_SEC_AL)
        sec_al_q <= i_wdata;
      else if (i_addr == rtb_pkg::OFS_MIN)
        min_q <= i_wdata;
      else if (i_addr == rtb_pkg::OFS_MIN_AL)
        min_al_q <= i_wdata;
      else if (i_addr == rtb_pkg::OFS_HOUR)
        hour_q <= i_wdata;
      else if (i_addr == rtb_pkg::OFS_HOUR_AL)
        hour_al_q <= i_wdata;
      else if (i_addr == rtb_pkg::OFS_WDAY)
        wday_q <= i_wdata;
      else if (i_addr == rtb_pkg::OFS_MDAY)
        mday_q <= i_wdata;
      else if (i_addr == rtb_pkg::OFS_MONTH)
        month_q <= i_wdata;
      else if (i_addr == rtb_pkg::OFS_YEAR)
        year_q <= i_wdata;
      else if (wr_bank1 && i_addr == rtb_pkg::OFS_CENTURY)
        century_q <= i_wdata;
      else if (wr_bank1 && i_addr == rtb_pkg::OFS_MDAY_AL)
        mday_al_q <= i_wdata;
    end
  end

  // Read mux; unmapped and bank-0 views of bank-1 bytes read zero
  always_comb
  begin
    rdata_d = rtb_pkg::READ_ZERO;
    if (i_addr == rtb_pkg::OFS_SEC)
      rdata_d = sec_q;
    else if (i_addr == rtb_pkg::OFS_SEC_AL)
      rdata_d = sec_al_q;
    else if (i_addr == rtb_pkg::OFS_MIN)
      rdata_d = min_q;
    else if (i_addr == rtb_pkg::OFS_MIN_AL)
      rdata_d = min_al_q;
    else if (i_addr == rtb_pkg::OFS_HOUR)
      rdata_d = hour_q;
    else if (i_addr == rtb_pkg::OFS_HOUR_AL)
      rdata_d = hour_al_q;
    else if (i_addr == rtb_pkg::OFS_WDAY)
      rdata_d = wday_q;
    else if (i_addr == rtb_pkg::OFS_MDAY)
      rdata_d = mday_q;
    else if (i_addr == rtb_pkg::OFS_MONTH)
      rdata_d = month_q;
    else if (i_addr == rtb_pkg::OFS_YEAR)
      rdata_d = year_q;
    else if (i_addr == rtb_pkg::OFS_OSC_RATE)
      rdata_d = {update_pending_q, osc_rate_q};
    else if (i_addr == rtb_pkg::OFS_MODE)
      rdata_d = mode_q;
    else if (i_addr == rtb_pkg::OFS_FLAGS)
      rdata_d[rtb_pkg::C_PERIODIC] = periodic_flag_q;
    else if (i_addr == rtb_pkg::OFS_BACKUP)
      rdata_d = rtb_pkg::BACKUP_VALID;
    else if (osc_rate_q[rtb_pkg::A_BANK_SEL])
    begin
      if (i_addr == rtb_pkg::OFS_CENTURY)
        rdata_d = century_q;
      else if (i_addr == rtb_pkg::OFS_MDAY_AL)
        rdata_d = mday_al_q;
      else if (i_addr == rtb_pkg::OFS_EXT_CTRL)
        rdata_d[rtb_pkg::EXT_FIXED_32KHZ_OUTPUT_ENABLE] = fixed_32khz_output_enable_q;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
      o_rdata <= '0;
    else if (i_rd)
      o_rdata <= rdata_d;
    else
      o_rdata <= '0;
  end

  // Pin outputs; fixed 32 kHz bypasses the rate tap for the pin only
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
      o_square_wave_pin <= 1'b0;
    else if (fixed_32khz_output_enable_q)
      o_square_wave_pin <= osc_lvl;
    else
      o_square_wave_pin <= tap && mode_q[rtb_pkg::B_SQUARE_WAVE_ENABLE];
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
      o_periodic_pulse <= 1'b0;
    else
      o_periodic_pulse <= tap_rise && mode_q[rtb_pkg::B_PIE];
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
      o_update_pulse <= 1'b0;
    else
      o_update_pulse <= do_update;
  end
endmodule : rtb_core

/* rtb_core_checker.sv */
// Property checker for the binary time and rate control block
module rtb_core_checker
(
  input wire logic       i_mclk,
  input wire logic       i_reset_n,
  input wire logic       i_osc_32k,
  input wire logic [6:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       o_square_wave_pin,
  input wire logic       o_periodic_pulse,
  input wire logic       o_update_pulse
);
  logic [6:0] osc_q;
  logic [7:0] mode_q;
  logic       fixed_32khz_output_enable_q;
  wire        run    = osc_q[6:5] == 2'h1;
  wire        rate0  = osc_q[3:0] == 4'h0;
  wire        set    = mode_q[7];
  wire        periodic_irq_enable    = mode_q[6];
  wire        square_wave_enable   = mode_q[3];
  wire        rd_osc = i_rd && i_addr == rtb_pkg::OFS_OSC_RATE;

  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);

  // Shadow of the control bits so each check knows the mode it runs in
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      osc_q  <= 7'h00;
      mode_q <= 8'h00;
      fixed_32khz_output_enable_q <= 1'b0;
    end
    else if (i_wr)
    begin
      if (i_addr == rtb_pkg::OFS_OSC_RATE)
        osc_q <= i_wdata[6:0];
      if (i_addr == rtb_pkg::OFS_MODE)
        mode_q <= i_wdata;
      if (i_addr == rtb_pkg::OFS_EXT_CTRL && osc_q[4])
        fixed_32khz_output_enable_q <= i_wdata[0];
    end
  end

  a_osc_readback:
    assert property (rd_osc |=> o_rdata[6:0] == osc_q)
      else $error("control readback wrong");
  a_pending_ro:
    assert property (rd_osc && !run && !$past(run) |=> !o_rdata[7])
      else $error("pending set while stopped");
  a_pending_clr:
    assert property (rd_osc && set && $past(set) |=> !o_rdata[7])
      else $error("pending set under inhibit");
  a_pending_lead:
    assert property (rd_osc && !set ##1 !o_rdata[7] |-> !o_update_pulse [*8])
      else $error("update too soon after clear pending");
  a_stop_quiet:
    assert property (!run && !$past(run) && !$past(run, 2) && !$past(run, 3)
      |-> !o_update_pulse && !o_periodic_pulse) else $error("event stopped");
  a_rate_off:
    assert property (rate0 && $past(rate0) && $past(rate0, 2)
      |-> !o_periodic_pulse) else $error("periodic at rate zero");
  a_pie_off:
    assert property (!periodic_irq_enable && !$past(periodic_irq_enable) && !$past(periodic_irq_enable, 2)
      |-> !o_periodic_pulse) else $error("periodic while disabled");
  a_square_low:
    assert property (!square_wave_enable && !fixed_32khz_output_enable_q && !$past(square_wave_enable) && !$past(fixed_32khz_output_enable_q)
      |-> !o_square_wave_pin) else $error("square while disabled");
  a_update_gap:
    assert property (o_update_pulse |=> !o_update_pulse [*8])
      else $error("updates too close");
  a_bank_hide:
    assert property (i_rd && !osc_q[4] && i_addr == rtb_pkg::OFS_CENTURY
      |=> o_rdata == 8'h00) else $error("bank one seen in bank zero");
  a_sec_msb:
    assert property (i_rd && i_addr == rtb_pkg::OFS_SEC |=> !o_rdata[7])
      else $error("seconds top bit set");

  c_update: cover property (o_update_pulse);
  c_fixed: cover property (o_periodic_pulse && fixed_32khz_output_enable_q);
  c_pending: cover property (rd_osc ##1 o_rdata[7]);
endmodule : rtb_core_checker

bind rtb_core rtb_core_checker i_chk (.i_mclk(i_mclk),
  .i_reset_n(i_reset_n), .i_osc_32k(i_osc_32k), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_square_wave_pin(o_square_wave_pin),
  .o_periodic_pulse(o_periodic_pulse), .o_update_pulse(o_update_pulse));

/* rtb_core_tb.sv */
// Self-checking bench for the binary time and rate control block
module rtb_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OSC_P = 4;
  logic       i_mclk    = 1'b0;
  logic       i_reset_n = 1'b0;
  logic       i_osc_32k = 1'b0;
  logic [6:0] i_addr    = 7'h00;
  logic [7:0] i_wdata   = 8'h00;
  logic       i_wr      = 1'b0;
  logic       i_rd      = 1'b0;
  logic [7:0] o_rdata;
  logic       o_square_wave_pin;
  logic       o_periodic_pulse;
  logic       o_update_pulse;
  logic [7:0] mdl [128];
  logic [7:0] got;
  logic [7:0] cen;
  int         mismatches = 0;
  int         checks     = 0;
  int         cyc        = 0;
  int         ph         = 0;
  int         p, n, t0;
  logic [6:0] ta [7] = '{7'h00, 7'h02, 7'h04, 7'h06, 7'h07, 7'h08, 7'h09};
  logic [7:0] tv [7] = '{8'h3B, 8'h3B, 8'h17, 8'h07, 8'h1F, 8'h0C, 8'h63};
  logic [7:0] te [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};

  rtb_core i_rtb_core (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .i_osc_32k(i_osc_32k), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_square_wave_pin(o_square_wave_pin),
    .o_periodic_pulse(o_periodic_pulse), .o_update_pulse(o_update_pulse));

  always #10 i_mclk = ~i_mclk;

  // Oscillator at a quarter of the clock: fastest the pin filter passes,
  // keeps the half-second wait inside the cycle budget
  always @(posedge i_mclk)
  begin
    cyc       <= cyc + 1;
    ph        <= (ph == OSC_P - 1) ? 0 : ph + 1;
    i_osc_32k <= ph < OSC_P / 2;
  end

  task automatic conclude();
    if (mismatches == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    mdl[a] = d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rc(input logic [6:0] a, input logic [7:0] e, input bit c);
    @(posedge i_mclk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 got = o_rdata;
    if (c)
      chk(got, e);
  endtask : rc

  // Spacing of the second and third rising edges skips a rate-change glitch
  task automatic gap(input bit sq, output int g);
    int k  = 0;
    int t1 = 0;
    bit s;
    bit pr = 1'b1;
    g = -1;
    for (int i = 0; i < 6000 && g < 0; i++)
    begin
      @(posedge i_mclk);
      #1 s = sq ? o_square_wave_pin : o_periodic_pulse;
      if (s && !pr)
      begin
        k++;
        t1 = (k == 2) ? cyc : t1;
        g  = (k == 3) ? cyc - t1 : g;
      end
      pr = s;
    end
    if (g < 0)
    begin
      chk(0, 1);
      conclude();
    end
  endtask : gap

  initial
  begin
    p = $urandom(24945);
    cen = 8'($urandom % 99);
    repeat (3) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    rc(rtb_pkg::OFS_OSC_RATE, 8'h00, 1);
    rc(7'h30, 8'h00, 1);
    wr(rtb_pkg::OFS_BACKUP, 8'hFF);
    wr(rtb_pkg::OFS_FLAGS, 8'hFF);
    rc(rtb_pkg::OFS_BACKUP, 8'h80, 1);
    rc(rtb_pkg::OFS_FLAGS, 8'h00, 1);
    wr(rtb_pkg::OFS_OSC_RATE, 8'hF0);
    rc(rtb_pkg::OFS_OSC_RATE, 8'h70, 1);
    wr(rtb_pkg::OFS_MODE, 8'h90);
    rc(rtb_pkg::OFS_MODE, 8'h80, 1);
    for (int a = 0; a < 10; a++)
      wr(7'(a), 8'($urandom));
    wr(rtb_pkg::OFS_CENTURY, cen);
    wr(rtb_pkg::OFS_MDAY_AL, 8'($urandom));
    mdl[0][7] = 1'b0;
    for (int a = 0; a < 10; a++)
      rc(7'(a), mdl[a], 1);
    rc(rtb_pkg::OFS_CENTURY, cen, 1);
    rc(rtb_pkg::OFS_MDAY_AL, mdl[7'h49], 1);
    wr(rtb_pkg::OFS_OSC_RATE, 8'h60);
    rc(rtb_pkg::OFS_CENTURY, 8'h00, 1);
    wr(rtb_pkg::OFS_MODE, 8'hCE);
    for (int r = 1; r < 9; r++)
    begin
      wr(rtb_pkg::OFS_OSC_RATE, 8'(32 + r));
      rc(rtb_pkg::OFS_OSC_RATE, 8'(32 + r), 1);
      gap(1'b0, p);
      chk(p, OSC_P * (r < 3 ? 64 << r : 1 << (r - 1)));
    end
    // Next tap rise is far off, so the clearing read cannot race it
    rc(rtb_pkg::OFS_FLAGS, 8'h40, 1);
    rc(rtb_pkg::OFS_FLAGS, 8'h00, 1);
    wr(rtb_pkg::OFS_OSC_RATE, 8'h23);
    gap(1'b1, p);
    chk(p, OSC_P * 4);
    wr(rtb_pkg::OFS_OSC_RATE, 8'h34);
    wr(rtb_pkg::OFS_EXT_CTRL, 8'h01);
    gap(1'b1, p);
    chk(p, OSC_P);
    gap(1'b0, p);
    chk(p, OSC_P * 8);
    wr(rtb_pkg::OFS_EXT_CTRL, 8'h00);
    wr(rtb_pkg::OFS_OSC_RATE, 8'h60);
    repeat (200) @(posedge i_mclk);
    for (int i = 0; i < 7; i++)
      wr(ta[i], tv[i]);
    wr(rtb_pkg::OFS_MODE, 8'h4E);
    wr(rtb_pkg::OFS_OSC_RATE, 8'h20);
    #1 t0 = cyc;
    got = 8'h00;
    for (n = 0; n < 40000 && got[7] !== 1'b1; n++)
      rc(rtb_pkg::OFS_OSC_RATE, 8'h00, 0);
    if (got[7] !== 1'b1)
    begin
      chk(0, 1);
      conclude();
    end
    n = 0;
    while (o_update_pulse !== 1'b1 && n < 100)
    begin
      @(posedge i_mclk);
      #1 n++;
    end
    chk(n >= 8 * OSC_P - 2 && n <= 10 * OSC_P, 1);
    chk(cyc - t0 >= 16383 * OSC_P
        && cyc - t0 <= 16384 * OSC_P + OSC_P, 1);
    if (n >= 100)
      conclude();
    for (int i = 0; i < 7; i++)
      rc(ta[i], te[i], 1);
    for (int a = 1; a < 6; a += 2)
      rc(7'(a), mdl[a], 1);
    wr(rtb_pkg::OFS_OSC_RATE, 8'h30);
    rc(rtb_pkg::OFS_CENTURY, cen + 8'h01, 1);
    conclude();
  end
endmodule : rtb_core_tb
